// File: rtl/bal_loader.sv
// module: boot memory auto-load sequencer, top level
//
// Overview of operation
// R1: start load at reset release if enabled
// R2: host drives load enable before reset release
// R3: load all registers and descriptor space
// R4: image begins with 64 register locations
// R5: unused register entries hold zero
// R6: descriptors go to ram at loaded pointer
// R7: all addresses generated internally
// R8: read 1088 bytes: 64, 512, 512
// R9: unused descriptor blocks filled with zeros
// R10: move 64-word blocks after access grant
// R11: accept bus commands only when fully enabled
// R12: boot select asserted during boot reads
// R13: boot address spans 8K bytes
// R14: 0 to 7 wait states per read
// R15: wait select captured at reset release
// R16: ready asserted when loading finishes
// R17: two bytes per select, address changes only
// R18: lower-addressed byte is low half
// R19: disabled load skips straight to ready
`timescale 1ns/100ps
module bal_loader (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_boot_load_enable_n,
  input wire logic [2:0] i_boot_wait_select,
  output logic o_boot_mem_select_n,
  output logic [bal_pkg::BOOT_AW-1:0] o_boot_addr,
  input wire logic [7:0] i_boot_data,
  output logic o_mem_req,
  input wire logic i_mem_grant,
  output logic o_reg_wr_valid,
  output logic [bal_pkg::REG_AW-1:0] o_reg_addr,
  input wire logic i_reg_wr_ready,
  output logic o_ram_wr_valid,
  output logic [bal_pkg::RAM_AW-1:0] o_ram_addr,
  input wire logic i_ram_wr_ready,
  output logic [15:0] o_wr_data,
  input wire logic i_start_execution_bit,
  input wire logic i_addr_parity_ok,
  output logic o_ready,
  output logic o_cmd_enable
);
  import bal_pkg::*;
  // ---------------------------------------------------------------
  // state machine and registers
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    S_INIT = 6'h01, // wait for synchronised straps
    S_GRANT = 6'h02, // wait for memory access
    S_BYTE = 6'h04, // boot read, two bytes
    S_PUSH = 6'h08, // hand word to buffer
    S_DRAIN = 6'h10, // let last writes finish
    S_DONE = 6'h20 // loading over
  } bal_state_e;
  bal_state_e st_q, st_d;
  logic [3:0] s1_q, s2_q, s3_q; // pin synchroniser stages
  logic [1:0] sc_q, sc_d; // synchroniser fill count
  logic [2:0] ws_q, ws_d; // captured wait select
  logic [9:0] idx_q, idx_d; // word index in image
  logic hi_q, hi_d; // reading upper byte
  logic [5:0] cnt_q, cnt_d; // wait-state countdown
  logic [7:0] lo_q, lo_d; // low byte held
  logic [15:0] wd_q, wd_d; // assembled word
  logic [RAM_AW-1:0] ptr_q, ptr_d; // descriptor pointer copy
  logic to_ram; // current word targets ram
  logic [RAM_AW-1:0] in_addr; // target word address of offered word
  bal_if bif ();
  // wait-state cycles for one byte
  function automatic logic [5:0] reload(input logic [2:0] ws);
    reload = 6'({3'h0, ws} * WS_CYC);
  endfunction
  // ---------------------------------------------------------------
  // pin synchronisers: load enable and wait select
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
    end else begin
      s1_q <= {i_boot_wait_select, i_boot_load_enable_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    sc_d = sc_q;
    ws_d = ws_q;
    idx_d = idx_q;
    hi_d = hi_q;
    cnt_d = cnt_q;
    lo_d = lo_q;
    wd_d = wd_q;
    ptr_d = ptr_q;
    unique case (st_q)
      // R15 capture wait select
      S_INIT: begin
        if (sc_q != SYNC_STAGES) begin
          sc_d = sc_q + 2'h1;
        end else if (s2_q == s3_q) begin
          ws_d = s3_q[3:1];
          // R1 start when enabled
          // R19 disabled skips loading
          st_d = s3_q[0] ? S_DONE : S_GRANT;
        end
      end
      // R10 block waits for grant
      S_GRANT: if (i_mem_grant) begin
        st_d = S_BYTE;
        hi_d = 1'b0;
        cnt_d = reload(ws_q);
      end
      // R14 wait states per byte
      S_BYTE: if (cnt_q != 6'h00) begin
        cnt_d = cnt_q - 6'h01;
      end else if (!hi_q) begin
        // R17 second byte by address change
        lo_d = i_boot_data;
        hi_d = 1'b1;
        cnt_d = reload(ws_q);
      end else begin
        // R18 low address is low half
        wd_d = {i_boot_data, lo_q};
        st_d = S_PUSH;
      end
      // word leaves when buffer has room
      S_PUSH: if (bif.in_ready) begin
        idx_d = idx_q + 10'h001;
        hi_d = 1'b0;
        cnt_d = reload(ws_q);
        // R6 pointer from loaded register
        if (idx_q == DESC_PTR_IDX) begin
          ptr_d = wd_q[RAM_AW-1:0];
        end
        // R8 stop after whole image
        if (idx_q == TOTAL_WORDS - 10'h001) begin
          st_d = S_DRAIN;
        end else if (idx_d[5:0] == 6'h00) begin
          st_d = S_GRANT;
        end else begin
          st_d = S_BYTE;
        end
      end
      // finish only when buffer empty
      S_DRAIN: if (!bif.out_valid) begin
        st_d = S_DONE;
      end
      S_DONE: st_d = S_DONE;
      default: st_d = S_INIT;
    endcase
  end
  // sequencer registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= S_INIT;
      sc_q <= 2'h0;
      ws_q <= 3'h0;
      idx_q <= 10'h000;
      hi_q <= 1'b0;
      cnt_q <= 6'h00;
      lo_q <= 8'h00;
      wd_q <= 16'h0000;
      ptr_q <= '0;
    end else begin
      st_q <= st_d;
      sc_q <= sc_d;
      ws_q <= ws_d;
      idx_q <= idx_d;
      hi_q <= hi_d;
      cnt_q <= cnt_d;
      lo_q <= lo_d;
      wd_q <= wd_d;
      ptr_q <= ptr_d;
    end
  end
  // ---------------------------------------------------------------
  // boot bus and write stream
  // ---------------------------------------------------------------
  // R12 select held across both bytes
  assign o_boot_mem_select_n = (st_q != S_BYTE);
  // R7 R13 internal byte address
  assign o_boot_addr = {2'h0, idx_q, hi_q};
  assign o_mem_req = (st_q == S_GRANT) || (st_q == S_BYTE) || (st_q == S_PUSH);
  // R3 first registers, then ram
  assign to_ram = (idx_q >= REG_WORDS);
  assign bif.in_valid = (st_q == S_PUSH);
  // one driver for the whole entry, fields packed in struct order
  assign in_addr = to_ram ? ptr_q + RAM_AW'(idx_q - REG_WORDS)
                          : {7'h00, idx_q[REG_AW-1:0]};
  assign bif.in_data = {to_ram, in_addr, wd_q};
  bal_buf u_buf (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .bif(bif.buf_side)
  );
  // buffer head to the write ports
  assign bif.out_ready = bif.out_data.to_ram ? i_ram_wr_ready : i_reg_wr_ready;
  assign o_reg_wr_valid = bif.out_valid && !bif.out_data.to_ram;
  assign o_ram_wr_valid = bif.out_valid && bif.out_data.to_ram;
  assign o_reg_addr = bif.out_data.addr[REG_AW-1:0];
  assign o_ram_addr = bif.out_data.addr;
  assign o_wr_data = bif.out_data.data;
  // R16 ready after loading
  assign o_ready = (st_q == S_DONE);
  // R11 commands need all three conditions
  assign o_cmd_enable = o_ready && i_start_execution_bit && i_addr_parity_ok;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [6:0] sel_len_q; // cycles of current select
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_len_q <= 7'h00;
    end else begin
      sel_len_q <= (st_q == S_BYTE) ? sel_len_q + 7'h01 : 7'h00;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  sequence q_decide;
    st_q == S_INIT && sc_q == SYNC_STAGES && s2_q == s3_q;
  endsequence
  property p_start;
    q_decide ##0 !s3_q[0] |=> st_q == S_GRANT && ws_q == $past(s3_q[3:1]);
  endproperty
  a_start: assert property (p_start) else $error("load did not start"); // R1
  property p_skip;
    q_decide ##0 s3_q[0] |=> o_ready && idx_q == 10'h000;
  endproperty
  a_skip: assert property (p_skip) else $error("disabled load not skipped"); // R19
  property p_sel_len;
    $rose(o_boot_mem_select_n) |-> 7'(sel_len_q) == 7'({reload(ws_q), 1'b0} + 7'h02);
  endproperty
  a_sel_len: assert property (p_sel_len) else $error("boot read length wrong"); // R14
  property p_two_bytes;
    st_q == S_BYTE && !hi_q && cnt_q == 6'h00 |=>
      !o_boot_mem_select_n && o_boot_addr == $past(o_boot_addr) + 13'h0001;
  endproperty
  a_two_bytes: assert property (p_two_bytes) else $error("byte step wrong"); // R17
  property p_ws_hold;
    st_q != S_INIT |=> $stable(ws_q);
  endproperty
  a_ws_hold: assert property (p_ws_hold) else $error("wait select changed"); // R15
  property p_grant;
    st_q == S_GRANT && !i_mem_grant |=> st_q == S_GRANT && o_boot_mem_select_n;
  endproperty
  a_grant: assert property (p_grant) else $error("read before grant"); // R10
  property p_ready;
    $rose(o_ready) |-> !bif.out_valid && (idx_q == TOTAL_WORDS || idx_q == 10'h000);
  endproperty
  a_ready: assert property (p_ready) else $error("ready too early"); // R16
  property p_cmd;
    o_cmd_enable |-> !bif.out_valid && !o_mem_req && o_boot_mem_select_n &&
      i_start_execution_bit && i_addr_parity_ok;
  endproperty
  a_cmd: assert property (p_cmd) else $error("commands enabled early"); // R11
  property p_ram_addr;
    st_q == S_PUSH && idx_q == REG_WORDS |-> bif.in_data.to_ram && bif.in_data.addr == ptr_q;
  endproperty
  a_ram_addr: assert property (p_ram_addr) else $error("ram address wrong"); // R6
  // pointer copy taken from the loaded pointer word
  property p_ptr_load;
    st_q == S_PUSH && idx_q == DESC_PTR_IDX && bif.in_ready |=>
      ptr_q == $past(wd_q[RAM_AW-1:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded"); // R6
endmodule

// File: rtl/bal_pkg.sv
// package: constants and types for the boot image auto-load block
package bal_pkg;
  // ---------------------------------------------------------------
  // clock and wait-state timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20; // system clock period
  localparam int WS_NS = 82; // one boot read wait state
  localparam logic [5:0] WS_CYC = 6'((WS_NS + CLK_NS - 1) / CLK_NS); // rounded up
  localparam logic [1:0] SYNC_STAGES = 2'h3; // pin synchroniser depth
  localparam logic [3:0] SYNC_RST = 4'h1; // load enable idle high, wait select zero
  // ---------------------------------------------------------------
  // boot image layout (byte locations, two bytes per word)
  // ---------------------------------------------------------------
  localparam int REG_BYTES = 64; // register image
  localparam int SA_BYTES = 512; // subaddress descriptors
  localparam int MC_BYTES = 512; // mode code descriptors
  localparam int TOTAL_BYTES = REG_BYTES + SA_BYTES + MC_BYTES; // 1088
  localparam logic [9:0] REG_WORDS = 10'(REG_BYTES / 2);
  localparam logic [9:0] TOTAL_WORDS = 10'(TOTAL_BYTES / 2);
  localparam logic [9:0] DESC_PTR_IDX = 10'h008; // descriptor pointer register
  localparam int BOOT_AW = 13; // 8K byte boot space
  localparam int RAM_AW = 12; // 4K word internal ram
  localparam int REG_AW = 5; // 32 registers
  // ---------------------------------------------------------------
  // buffered write entry
  // ---------------------------------------------------------------
  typedef struct packed {
    logic to_ram; // 1: ram write, 0: register write
    logic [RAM_AW-1:0] addr; // word address
    logic [15:0] data; // assembled word
  } bal_entry_s;
endpackage

// File: rtl/bal_if.sv
// interface: write stream between the loader and its two-entry buffer
`timescale 1ns/100ps
interface bal_if;
  import bal_pkg::*;
  logic in_valid; // loader offers a word
  logic in_ready; // buffer has room
  bal_entry_s in_data; // offered word
  logic out_valid; // buffer holds a word
  logic out_ready; // write target takes it
  bal_entry_s out_data; // head word
  modport src (output in_valid, output in_data, input in_ready,
               input out_valid, input out_data, output out_ready);
  modport buf_side (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
endinterface

// File: rtl/bal_buf.sv
// module: two-entry flip-flop buffer with valid/ready on both sides
`timescale 1ns/100ps
module bal_buf (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  bal_if.buf_side bif
);
  import bal_pkg::*;
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  bal_entry_s mem_q [2]; // two entries
  bal_entry_s mem_d [2];
  logic wp_q, wp_d; // write index
  logic rp_q, rp_d; // read index
  logic [1:0] cnt_q, cnt_d; // fill level
  logic push, pop;
  // handshakes: honest full and empty
  assign bif.in_ready = (cnt_q != 2'h2);
  assign bif.out_valid = (cnt_q != 2'h0);
  assign bif.out_data = mem_q[rp_q];
  assign push = bif.in_valid && bif.in_ready;
  assign pop = bif.out_valid && bif.out_ready;
  // next state of pointers and entries
  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = bif.in_data;
      wp_d = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  // register only
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// File: testbench/bal_boot_mem.sv
// partner model: byte-wide boot memory read by the loader
`timescale 1ns/100ps
module bal_boot_mem (
  input wire logic i_sel_n,
  input wire logic [12:0] i_addr,
  input wire logic i_slow,
  output logic [7:0] o_data
);
  // image pattern, zero where entries are unused
  function automatic logic [7:0] img(input int a);
    if (a >= 20 && a < 32) begin
      return 8'h00;
    end
    if (a >= 1056) begin
      return 8'h00;
    end
    return 8'(a) ^ 8'(a >> 8) ^ 8'hA5;
  endfunction
  initial o_data = 8'hFF;
  // data is garbage until the access time has run out
  always @(i_addr, i_sel_n) begin
    o_data <= ~o_data;
    if (!i_sel_n) begin
      o_data <= #(i_slow ? 250 : 10) img(int'(i_addr));
    end
  end
endmodule

// File: testbench/test_bal_loader.sv
// testbench: self-checking runs of the boot image loader
`timescale 1ns/100ps
module test_bal_loader;
  import bal_pkg::*;
  logic clk, rstn, en_n, req, grant, sel_n, rv, rr, mv, mr, start_execution_bit, par, rdy, cmde;
  logic slow, stall, mon, prev_sel, hold_v;
  logic [2:0] ws, cur_ws;
  logic [12:0] baddr, prev_a;
  logic [7:0] bdata, cyc;
  logic [4:0] ra;
  logic [11:0] ma, ptr;
  logic [15:0] wdata;
  logic [34:0] held;
  int nb, nw, lowc, tests_run, bad_count;
  // -------------------------------------------------------------
  // design, memory model, clock
  // -------------------------------------------------------------
  bal_loader dut (.i_clk_sys(clk), .i_resetn(rstn), .i_boot_load_enable_n(en_n),
    .i_boot_wait_select(ws), .o_boot_mem_select_n(sel_n), .o_boot_addr(baddr),
    .i_boot_data(bdata), .o_mem_req(req), .i_mem_grant(grant), .o_reg_wr_valid(rv),
    .o_reg_addr(ra), .i_reg_wr_ready(rr), .o_ram_wr_valid(mv), .o_ram_addr(ma),
    .i_ram_wr_ready(mr), .o_wr_data(wdata), .i_start_execution_bit(start_execution_bit),
    .i_addr_parity_ok(par), .o_ready(rdy), .o_cmd_enable(cmde));
  bal_boot_mem mem (.i_sel_n(sel_n), .i_addr(baddr), .i_slow(slow), .o_data(bdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // expected image byte and word
  function automatic logic [7:0] rb(input int a);
    if ((a >= 20 && a < 32) || a >= 1056) begin
      return 8'h00;
    end
    return 8'(a) ^ 8'(a >> 8) ^ 8'hA5;
  endfunction
  function automatic logic [15:0] ew(input int i);
    return {rb(2 * i + 1), rb(2 * i)};
  endfunction
  function automatic bit miss(input logic c);
    tests_run++;
    return c !== 1'b1;
  endfunction
  task automatic bad(input string m);
    bad_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // write targets, grant and stream monitor
  // -------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 8'h01;
    rr <= !stall || cyc[5:4] != 2'h0;
    mr <= !stall || cyc[6:5] != 2'h1;
    grant <= req && cyc[2:0] == 3'h0;
    if (mon) begin
      if (!sel_n && (prev_sel || baddr !== prev_a)) begin
        if (miss(baddr === 13'(nb))) bad("boot address out of order");
        nb++;
      end
      if (!sel_n) begin
        lowc++;
      end else if (!prev_sel) begin
        if (miss(lowc == 2 * (1 + 5 * cur_ws))) bad("select width");
        lowc = 0;
      end
      if (miss(sel_n === 1'b1 || req === 1'b1)) bad("select outside access");
      if (hold_v && miss({rv, mv, ra, ma, wdata} === held)) bad("write moved");
      if (rv && rr) begin
        if (miss(ra === 5'(nw) && wdata === ew(nw))) bad("register write");
        nw++;
      end
      if (mv && mr) begin
        if (miss(nw >= 32 && ma === 12'(ptr + nw - 32) && wdata === ew(nw))) bad("ram write");
        nw++;
      end
    end
    prev_sel <= sel_n;
    prev_a <= baddr;
    hold_v <= (rv && !rr) || (mv && !mr);
    held <= {rv, mv, ra, ma, wdata};
  end
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic start(input logic [2:0] w, input logic e);
    rstn <= 1'b0;
    en_n <= e;
    ws <= w;
    mon <= 1'b0;
    repeat (3) @(posedge clk);
    if (miss(sel_n === 1'b1 && !rv && !mv && !rdy && !cmde)) bad("reset state");
    rstn <= 1'b1;
    mon <= 1'b1;
    nb = 0;
    nw = 0;
    lowc = 0;
    cur_ws = w;
  endtask
  task automatic wait_ready(input int lim);
    int i;
    i = 0;
    while (rdy !== 1'b1 && i < lim) begin
      @(posedge clk);
      i++;
      if (miss(rdy === 1'b1 || cmde === 1'b0)) bad("commands open early");
    end
    if (miss(rdy === 1'b1)) bad("ready missing");
  endtask
  task automatic run_load(input logic [2:0] w, input logic s_slow, input logic s_stall);
    int k;
    @(posedge clk);
    slow <= s_slow;
    stall <= s_stall;
    start_execution_bit <= 1'b1;
    par <= 1'b1;
    start(w, 1'b0);
    repeat (30) @(posedge clk);
    ws <= ~w;
    wait_ready(60000);
    repeat (4) @(posedge clk);
    if (miss(nb == 1088 && nw == 544)) bad("image size");
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {start_execution_bit, par} <= 2'(k);
      @(negedge clk);
      if (miss(cmde === (k == 3))) bad("command gate");
    end
  endtask
  task automatic abort_skip;
    slow <= 1'b0;
    stall <= 1'b0;
    start_execution_bit <= 1'b1;
    par <= 1'b1;
    start(3'h0, 1'b0);
    repeat (200) @(posedge clk);
    start(3'h0, 1'b1);
    wait_ready(20);
    repeat (20) @(posedge clk);
    if (miss(nb == 0 && nw == 0 && sel_n === 1'b1)) bad("skip touched memory");
  endtask
  // main sequence
  initial begin
    rstn = 1'b0;
    en_n = 1'b1;
    ws = 3'h0;
    grant = 1'b0;
    rr = 1'b0;
    mr = 1'b0;
    start_execution_bit = 1'b0;
    par = 1'b0;
    slow = 1'b0;
    stall = 1'b0;
    mon = 1'b0;
    cyc = 8'h00;
    prev_sel = 1'b1;
    hold_v = 1'b0;
    tests_run = 0;
    bad_count = 0;
    ptr = 12'({rb(17), rb(16)});
    abort_skip();
    run_load(3'h0, 1'b0, 1'b1);
    run_load(3'h3, 1'b1, 1'b1);
    run_load(3'h7, 1'b1, 1'b0);
    wrap_up();
  end
  // watchdog against a hung load: runs take about 61k cycles, limit 90k
  initial begin
    #1800000;
    bad("watchdog expired");
    wrap_up();
  end
endmodule
